/* rtl/qct_pkg.sv */
/*
  qct_pkg: constants shared by the quad counter/timer block.
  assumes a single system clock domain and synchronous reset.
*/
package qct_pkg;
  // ----------------------------------------------------------------
  // prescale and divider figures
  // ----------------------------------------------------------------
  localparam int unsigned QCT_DIV_SYS12    = 12;
  localparam int unsigned QCT_DIV_SYS4     = 4;
  localparam int unsigned QCT_DIV_SYS48    = 48;
  localparam int unsigned QCT_DIV_EXT8     = 8;
  localparam int unsigned QCT_DIVCNT_W     = 6;
  localparam logic [1:0]  QCT_SCA_SYS12    = 2'h0;
  localparam logic [1:0]  QCT_SCA_SYS4     = 2'h1;
  localparam logic [1:0]  QCT_SCA_SYS48    = 2'h2;
  localparam logic [1:0]  QCT_SCA_EXT8     = 2'h3;
  // ----------------------------------------------------------------
  // reset values and 13-bit count limit
  // ----------------------------------------------------------------
  localparam logic [15:0] QCT_CNT_RST      = 16'h0000;
  localparam logic [5:0]  QCT_DIV_RST      = 6'h00;
  localparam logic [12:0] QCT_MAX13        = 13'h1fff;

  typedef enum logic [1:0] {
    QCT_MODE_13BIT = 2'b00,
    QCT_MODE_16BIT = 2'b01,
    QCT_MODE_8RELD = 2'b10,
    QCT_MODE_SPLIT = 2'b11
  } qct_mode_e;

  // timer 2/3 clock choice
  typedef enum logic [1:0] {
    QCT_TCK_SYS12 = 2'b00,
    QCT_TCK_EXT8  = 2'b01,
    QCT_TCK_SYS   = 2'b10
  } qct_tclk_e;
endpackage

/* rtl/qct_reload_timer.sv */
/*
  qct_reload_timer: one auto-reload timer, 16-bit or split 8+8.
  assumes tick inputs are one-cycle strobes on mclk.
*/
`timescale 1ns/1ns
`default_nettype none
module qct_reload_timer
  import qct_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // control
  input  wire logic        run,
  input  wire logic        split,
  input  wire logic        tick_lo,
  input  wire logic        tick_hi,
  input  wire logic [15:0] reload,
  // status
  output logic      [15:0] count_q,
  output logic             ovf_lo,
  output logic             ovf_hi
);
  logic [15:0] count_d;
  logic        wrap_lo;
  logic        wrap_hi;

  assign wrap_lo = run && tick_lo && (split ? count_q[7:0] == 8'hff
                                            : count_q == 16'hffff);
  assign wrap_hi = run && tick_hi && split && count_q[15:8] == 8'hff;
  assign ovf_lo  = wrap_lo;
  assign ovf_hi  = split ? wrap_hi : 1'b0;

  always_comb begin
    count_d = count_q;
    if (run && !split && tick_lo) begin
      count_d = wrap_lo ? reload : count_q + 16'h0001;
    end
    if (run && split && tick_lo) begin
      count_d[7:0] = wrap_lo ? reload[7:0] : count_q[7:0] + 8'h01;
    end
    if (run && split && tick_hi) begin
      count_d[15:8] = wrap_hi ? reload[15:8] : count_q[15:8] + 8'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      count_q <= QCT_CNT_RST;
    end else begin
      count_q <= count_d;
    end
  end

  a_reload_value: assert property (@(posedge mclk) disable iff (sys_rst)
    (wrap_lo && !split) |=> count_q == $past(reload))
    else $error("16-bit reload value wrong");
endmodule
`default_nettype wire

/* rtl/qct_top.sv */
/*
  qct_top: four counter/timers with prescaler and pin event counting.
  assumes count pins and ext_osc are asynchronous to mclk; the cpu
  side supplies control bits as plain levels on mclk.
*/
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - four 16-bit counter/timers, two classic, two auto-reload.
// - units 0/1 do 13-bit, 16-bit, 8-bit reload; split on unit 0 only.
// - timers 2/3 run as one 16-bit or two 8-bit reload timers.
// - timer 3 counts ext clock in suspend and can wake the device.
// - unit 0/1 clock from five sources via select bit and prescale.
// - each unit 0/1 picks prescaled clock or undivided system clock.
// - timers 2/3 use sysclk, sysclk/12 or ext clock/8.
// - in counter mode increment on each falling edge of its pin.
// - events up to a quarter of the system clock are counted.
// - units raise overflow interrupt requests for periodic interrupts.
// - prescale 00 /12, 01 /4, 10 /48, 11 ext/8 synchronised.
// - 13-bit wrap from all ones sets flag and requests interrupt.
module qct_top
  import qct_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // pins
  input  wire logic        count_input_pin_a,
  input  wire logic        count_input_pin_b,
  input  wire logic        ext_osc,
  input  wire logic        suspend,
  // unit 0/1 control
  input  wire logic [1:0]  shared_prescale_field,
  input  wire logic [1:0]  unit_clock_select_bits,
  input  wire logic [1:0]  unit_run,
  input  wire logic [1:0]  unit_counter_mode,
  input  wire qct_mode_e   unit_a_mode,
  input  wire qct_mode_e   unit_b_mode,
  input  wire logic [1:0]  unit_irq_en,
  input  wire logic [1:0]  unit_flag_clr,
  // timer 2/3 control
  input  wire logic [1:0]  rt_run,
  input  wire logic [1:0]  rt_split,
  input  wire qct_tclk_e   rt2_clk_lo,
  input  wire qct_tclk_e   rt2_clk_hi,
  input  wire qct_tclk_e   rt3_clk_lo,
  input  wire qct_tclk_e   rt3_clk_hi,
  input  wire logic [15:0] rt2_reload,
  input  wire logic [15:0] rt3_reload,
  input  wire logic [3:0]  rt_irq_en,
  input  wire logic [3:0]  rt_flag_clr,
  // status
  output logic      [15:0] unit_a_count_q,
  output logic      [15:0] unit_b_count_q,
  output logic      [15:0] rt2_count_q,
  output logic      [15:0] rt3_count_q,
  output logic             unit_a_overflow_flag,
  output logic             unit_b_overflow_flag,
  output logic             unit_a_hi_overflow_flag,
  output logic      [3:0]  rt_flags_q,
  output logic      [3:0]  irq_req,
  output logic             wake_req
);
  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] prev_q;
  logic [2:0] fall;
  logic       ext_rise;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sync1_q <= 3'h7;
      sync2_q <= 3'h7;
      prev_q  <= 3'h7;
    end else begin
      sync1_q <= {ext_osc, count_input_pin_b, count_input_pin_a};
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end
  assign fall     = prev_q & ~sync2_q;
  assign ext_rise = ~prev_q[2] & sync2_q[2];

  // ----------------------------------------------------------------
  // dividers
  // ----------------------------------------------------------------
  logic [QCT_DIVCNT_W-1:0] div12_q;
  logic [QCT_DIVCNT_W-1:0] div4_q;
  logic [QCT_DIVCNT_W-1:0] div48_q;
  logic [QCT_DIVCNT_W-1:0] ext8_q;
  logic                    t12;
  logic                    t4;
  logic                    t48;
  logic                    te8;
  logic                    pre_tick;

  localparam logic [5:0] LAST12 = 6'(QCT_DIV_SYS12 - 1);
  localparam logic [5:0] LAST4  = 6'(QCT_DIV_SYS4 - 1);
  localparam logic [5:0] LAST48 = 6'(QCT_DIV_SYS48 - 1);
  localparam logic [5:0] LAST8  = 6'(QCT_DIV_EXT8 - 1);

  assign t12 = div12_q == LAST12;
  assign t4  = div4_q == LAST4;
  assign t48 = div48_q == LAST48;
  assign te8 = ext_rise && ext8_q == LAST8;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      div12_q <= QCT_DIV_RST;
      div4_q  <= QCT_DIV_RST;
      div48_q <= QCT_DIV_RST;
      ext8_q  <= QCT_DIV_RST;
    end else begin
      div12_q <= t12 ? QCT_DIV_RST : div12_q + 6'h01;
      div4_q  <= t4 ? QCT_DIV_RST : div4_q + 6'h01;
      div48_q <= t48 ? QCT_DIV_RST : div48_q + 6'h01;
      if (ext_rise) begin
        ext8_q <= (ext8_q == LAST8) ? QCT_DIV_RST : ext8_q + 6'h01;
      end
    end
  end

  always_comb begin
    unique case (shared_prescale_field)
      QCT_SCA_SYS12: pre_tick = t12;
      QCT_SCA_SYS4:  pre_tick = t4;
      QCT_SCA_SYS48: pre_tick = t48;
      QCT_SCA_EXT8:  pre_tick = te8;
    endcase
  end

  // ----------------------------------------------------------------
  // units 0 and 1
  // ----------------------------------------------------------------
  logic [1:0] utick;
  logic [15:0] ua_d;
  logic [15:0] ub_d;
  logic       wa;
  logic       wb;
  logic       wa_hi;
  logic       fa_q;
  logic       fb_q;
  logic       fah_q;

  generate
    for (genvar i = 0; i < 2; i++) begin : g_utick
      assign utick[i] = unit_counter_mode[i] ? fall[i]
                      : (unit_clock_select_bits[i] ? 1'b1 : pre_tick);
    end
  endgenerate

  function automatic logic [16:0] step(input logic [15:0] c,
                                       input qct_mode_e   m,
                                       input logic        tk);
    logic [16:0] r;
    r = {1'b0, c};
    if (tk) begin
      unique case (m)
        QCT_MODE_13BIT: begin
          r[12:0] = c[12:0] + 13'h0001;
          r[16]   = c[12:0] == QCT_MAX13;
        end
        QCT_MODE_16BIT: begin
          r[15:0] = c + 16'h0001;
          r[16]   = c == 16'hffff;
        end
        QCT_MODE_8RELD: begin
          r[7:0] = (c[7:0] == 8'hff) ? c[15:8] : c[7:0] + 8'h01;
          r[16]  = c[7:0] == 8'hff;
        end
        QCT_MODE_SPLIT: begin
          r[7:0] = c[7:0] + 8'h01;
          r[16]  = c[7:0] == 8'hff;
        end
      endcase
    end
    return r;
  endfunction

  always_comb begin
    {wa, ua_d} = step(unit_a_count_q, unit_a_mode, unit_run[0] & utick[0]);
    // split is unit 0 only; unit 1 just holds in that mode
    if (unit_b_mode == QCT_MODE_SPLIT) begin
      {wb, ub_d} = {1'b0, unit_b_count_q};
    end else begin
      {wb, ub_d} = step(unit_b_count_q, unit_b_mode,
                        unit_run[1] & utick[1]);
    end
    // split high half counts the shared prescale tick pre_tick and uses unit 1 run bit
    wa_hi = 1'b0;
    if (unit_a_mode == QCT_MODE_SPLIT && unit_run[1] && pre_tick) begin
      ua_d[15:8] = unit_a_count_q[15:8] + 8'h01;
      wa_hi      = unit_a_count_q[15:8] == 8'hff;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      unit_a_count_q <= QCT_CNT_RST;
      unit_b_count_q <= QCT_CNT_RST;
    end else begin
      unit_a_count_q <= ua_d;
      unit_b_count_q <= ub_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      fa_q  <= 1'b0;
      fb_q  <= 1'b0;
      fah_q <= 1'b0;
    end else begin
      fa_q  <= wa | (fa_q & ~unit_flag_clr[0]);
      fb_q  <= wb | (fb_q & ~unit_flag_clr[1]);
      fah_q <= wa_hi | (fah_q & ~unit_flag_clr[1]);
    end
  end
  assign unit_a_overflow_flag    = fa_q;
  assign unit_b_overflow_flag    = fb_q;
  assign unit_a_hi_overflow_flag = fah_q;

  // ----------------------------------------------------------------
  // timers 2 and 3
  // ----------------------------------------------------------------
  logic [3:0] rtick;
  logic [3:0] rovf;
  logic [3:0] rf_q;
  logic       rt3_run;
  qct_tclk_e  rsel [4];

  assign rsel[0] = rt2_clk_lo;
  assign rsel[1] = rt2_clk_hi;
  assign rsel[2] = suspend ? QCT_TCK_EXT8 : rt3_clk_lo;
  assign rsel[3] = suspend ? QCT_TCK_EXT8 : rt3_clk_hi;

  generate
    for (genvar j = 0; j < 4; j++) begin : g_rtick
      assign rtick[j] = (rsel[j] == QCT_TCK_SYS) ? 1'b1
                      : (rsel[j] == QCT_TCK_EXT8) ? te8 : t12;
    end
  endgenerate
  assign rt3_run = rt_run[1];

  qct_reload_timer u_rt2 (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .run     (rt_run[0] & ~suspend),
    .split   (rt_split[0]),
    .tick_lo (rtick[0]),
    .tick_hi (rtick[1]),
    .reload  (rt2_reload),
    .count_q (rt2_count_q),
    .ovf_lo  (rovf[0]),
    .ovf_hi  (rovf[1])
  );
  qct_reload_timer u_rt3 (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .run     (rt3_run),
    .split   (rt_split[1]),
    .tick_lo (rtick[2]),
    .tick_hi (rtick[3]),
    .reload  (rt3_reload),
    .count_q (rt3_count_q),
    .ovf_lo  (rovf[2]),
    .ovf_hi  (rovf[3])
  );

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rf_q <= 4'h0;
    end else begin
      rf_q <= rovf | (rf_q & ~rt_flag_clr);
    end
  end
  assign rt_flags_q = rf_q;

  assign irq_req[0] = fa_q & unit_irq_en[0];
  assign irq_req[1] = (fb_q | fah_q) & unit_irq_en[1];
  assign irq_req[2] = |(rf_q[1:0] & rt_irq_en[1:0]);
  assign irq_req[3] = |(rf_q[3:2] & rt_irq_en[3:2]);
  assign wake_req   = suspend & |(rf_q[3:2] & rt_irq_en[3:2]);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_fall_count: assert property (@(posedge mclk) disable iff (sys_rst)
    (unit_counter_mode[0] && unit_run[0] && fall[0]
     && unit_a_mode == QCT_MODE_16BIT)
    |=> unit_a_count_q == $past(unit_a_count_q) + 16'h0001)
    else $error("pin fall did not count");
  a_sync_delay: assert property (@(posedge mclk) disable iff (sys_rst)
    fall[0] |-> $past(count_input_pin_a, 3) && !$past(count_input_pin_a, 2))
    else $error("edge not from synced samples");
  a_wrap_13bit: assert property (@(posedge mclk) disable iff (sys_rst)
    (unit_a_mode == QCT_MODE_13BIT && unit_run[0] && utick[0]
     && unit_a_count_q[12:0] == QCT_MAX13)
    |=> unit_a_count_q[12:0] == 13'h0000 && fa_q)
    else $error("13-bit wrap missed");
  a_flag_sticky: assert property (@(posedge mclk) disable iff (sys_rst)
    (fa_q && !unit_flag_clr[0]) |=> fa_q)
    else $error("flag dropped without clear");
  a_irq_gate: assert property (@(posedge mclk) disable iff (sys_rst)
    irq_req[0] == (fa_q && unit_irq_en[0]))
    else $error("irq not gated by enable");
  a_pre_div12: assert property (@(posedge mclk) disable iff (sys_rst)
    t12 |=> !t12 [*8] ##1 !t12 ##1 !t12 ##1 !t12 ##1 t12)
    else $error("div 12 period wrong");
  a_pre_div4: assert property (@(posedge mclk) disable iff (sys_rst)
    t4 |=> !t4 ##1 !t4 ##1 !t4 ##1 t4)
    else $error("div 4 period wrong");
  a_sysclk_sel: assert property (@(posedge mclk) disable iff (sys_rst)
    (unit_clock_select_bits[1] && !unit_counter_mode[1]) |-> utick[1])
    else $error("sysclk select not undivided");
  a_split_b_hold: assert property (@(posedge mclk) disable iff (sys_rst)
    (unit_b_mode == QCT_MODE_SPLIT) |=> $stable(unit_b_count_q))
    else $error("unit 1 counted in split");
  a_suspend_ext: assert property (@(posedge mclk) disable iff (sys_rst)
    suspend |-> rtick[2] == te8)
    else $error("timer 3 not on ext clock");
  a_rt_clock: assert property (@(posedge mclk) disable iff (sys_rst)
    (rt2_clk_lo == QCT_TCK_SYS12) |-> rtick[0] == t12)
    else $error("timer 2 clock select wrong");
  a_event_rate: assert property (@(posedge mclk) disable iff (sys_rst)
    fall[0] |=> !fall[0])
    else $error("edge counted twice");

  c_wrap13: cover property (@(posedge mclk) wa && unit_a_mode == QCT_MODE_13BIT);
  c_pin_count: cover property (@(posedge mclk) fall[1] && unit_run[1]);
  c_wake: cover property (@(posedge mclk) wake_req);
  c_split_hi: cover property (@(posedge mclk) wa_hi);
endmodule
`default_nettype wire

/* tb/qct_pin_src.sv */
/*
  qct_pin_src: far-side model of the two count pins and the external
  oscillator. assumes falls() is called just after a rising mclk.
*/
`timescale 1ns/1ns
`default_nettype none
module qct_pin_src #(
  parameter int OSC_HALF = 3
) (
  // clock
  input  wire logic mclk,
  // pins
  output var  logic pin_a,
  output var  logic pin_b,
  output var  logic osc
);
  // ----------------------------------------------------------------
  // external oscillator
  // ----------------------------------------------------------------
  // free running, each level held three cycles
  initial begin
    osc = 1'b0;
    forever begin
      repeat (OSC_HALF) @(posedge mclk);
      #1 osc = ~osc;
    end
  end

  // ----------------------------------------------------------------
  // event pins
  // ----------------------------------------------------------------
  initial begin
    pin_a = 1'b1;
    pin_b = 1'b1;
  end

  // hold every level for at least two cycles
  task automatic falls(input bit b, input int n, input int hold);
    repeat (2 * n) begin
      repeat (hold) @(posedge mclk);
      #1;
      if (b) pin_b = ~pin_b;
      else pin_a = ~pin_a;
    end
  endtask
endmodule
`default_nettype wire

/* tb/quad_counter_timer_clocking_tb.sv */
/*
  quad_counter_timer_clocking_tb: self-checking bench for qct_top.
  assumes the pin model drives pins and oscillator one ns after mclk.
*/
`timescale 1ns/1ns
`default_nettype none
module quad_counter_timer_clocking_tb;
  import qct_pkg::*;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        suspend = 1'b0;
  logic [1:0]  shared_prescale_field = 2'h0;
  logic [1:0]  unit_clock_select_bits = 2'h0;
  logic [1:0]  unit_run = 2'h0;
  logic [1:0]  unit_counter_mode = 2'h0;
  logic [1:0]  unit_irq_en = 2'h0;
  logic [1:0]  unit_flag_clr = 2'h0;
  logic [1:0]  rt_run = 2'h0;
  logic [1:0]  rt_split = 2'h0;
  logic [3:0]  rt_irq_en = 4'h0;
  logic [3:0]  rt_flag_clr = 4'h0;
  logic [15:0] rt2_reload = 16'h0000;
  logic [15:0] rt3_reload = 16'h0000;
  qct_mode_e   unit_a_mode = QCT_MODE_16BIT;
  qct_mode_e   unit_b_mode = QCT_MODE_16BIT;
  qct_tclk_e   rt2_clk_lo = QCT_TCK_SYS;
  qct_tclk_e   rt2_clk_hi = QCT_TCK_SYS12;
  qct_tclk_e   rt3_clk_lo = QCT_TCK_SYS;
  qct_tclk_e   rt3_clk_hi = QCT_TCK_SYS12;
  logic [15:0] unit_a_count_q, unit_b_count_q, rt2_count_q, rt3_count_q;
  logic        unit_a_overflow_flag, unit_b_overflow_flag;
  logic        unit_a_hi_overflow_flag, wake_req;
  logic [3:0]  rt_flags_q, irq_req;
  logic        count_input_pin_a, count_input_pin_b, ext_osc;
  int          mismatches = 0;
  int          total_checks = 0;

  always #20 mclk = ~mclk;

  qct_pin_src u_src (.mclk, .pin_a(count_input_pin_a),
    .pin_b(count_input_pin_b), .osc(ext_osc));

  qct_top u_dut (.mclk, .sys_rst, .count_input_pin_a, .count_input_pin_b,
    .ext_osc, .suspend, .shared_prescale_field, .unit_clock_select_bits,
    .unit_run, .unit_counter_mode, .unit_a_mode, .unit_b_mode,
    .unit_irq_en, .unit_flag_clr, .rt_run, .rt_split, .rt2_clk_lo,
    .rt2_clk_hi, .rt3_clk_lo, .rt3_clk_hi, .rt2_reload, .rt3_reload,
    .rt_irq_en, .rt_flag_clr, .unit_a_count_q, .unit_b_count_q,
    .rt2_count_q, .rt3_count_q, .unit_a_overflow_flag,
    .unit_b_overflow_flag, .unit_a_hi_overflow_flag, .rt_flags_q,
    .irq_req, .wake_req);

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // free-running dividers leave the phase open, so allow a tolerance
  task automatic near(input string what, input logic [31:0] seen,
                      input int exp, input int tol);
    if (seen + tol >= exp && seen <= exp + tol) check(what, exp, exp);
    else check(what, seen, exp);
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  function automatic logic pick(input int k);
    case (k)
      0: return unit_a_overflow_flag;
      1: return rt_flags_q[0];
      2: return rt_flags_q[2];
      default: return unit_a_hi_overflow_flag;
    endcase
  endfunction

  task automatic wait_hi(input int k, input int lim, output int n);
    n = 0;
    while (pick(k) !== 1'b1) begin
      step(1);
      n++;
      if (n > lim) begin
        mismatches++;
        $display("[ERR] flag %0d wait ran out", k);
        test_done();
      end
    end
  endtask

  task automatic pulse_rt_clr(input logic [3:0] m);
    rt_flag_clr = m;
    step(1);
    rt_flag_clr = 4'h0;
  endtask

  task automatic do_reset();
    sys_rst = 1'b1;
    step(5);
    sys_rst = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_pins();
    logic [15:0] a0, b0;
    unit_counter_mode = 2'b11;
    unit_run = 2'b11;
    step(2);
    a0 = unit_a_count_q;
    b0 = unit_b_count_q;
    u_src.falls(0, 5, 2);
    step(4);
    check("pin a count", unit_a_count_q, a0 + 16'h0005);
    check("pin b idle", unit_b_count_q, b0);
    u_src.falls(1, 3, 3);
    step(4);
    check("pin b count", unit_b_count_q, b0 + 16'h0003);
    unit_run = 2'b00;
    u_src.falls(0, 2, 2);
    step(4);
    check("stopped pin a", unit_a_count_q, a0 + 16'h0005);
  endtask

  task automatic t_presc();
    int div[4] = '{12, 4, 48, 48};
    logic [15:0] s, sb;
    unit_counter_mode = 2'b00;
    unit_run = 2'b11;
    for (int k = 0; k < 4; k++) begin
      shared_prescale_field = 2'(k);
      step(60);
      s = unit_a_count_q;
      step(480);
      near("prescaled", 32'(unit_a_count_q - s), 480 / div[k], 1);
    end
    unit_clock_select_bits = 2'b10;
    shared_prescale_field = QCT_SCA_SYS4;
    step(60);
    s = unit_a_count_q;
    sb = unit_b_count_q;
    step(100);
    near("a on prescale", 32'(unit_a_count_q - s), 25, 1);
    check("b on sysclk", 32'(unit_b_count_q - sb), 100);
  endtask

  task automatic t_wrap13();
    int n;
    unit_run = 2'b01;
    unit_clock_select_bits = 2'b01;
    unit_a_mode = QCT_MODE_13BIT;
    unit_irq_en = 2'b01;
    do_reset();
    wait_hi(0, 8300, n);
    near("wrap cycles", n, 8192, 2);
    check("wrap count", unit_a_count_q[12:0], 13'h0000);
    check("unit irq", irq_req[0], 1'b1);
    unit_irq_en = 2'b00;
    step(1);
    check("irq masked", irq_req[0], 1'b0);
    unit_flag_clr = 2'b01;
    step(1);
    unit_flag_clr = 2'b00;
    step(1);
    check("flag cleared", unit_a_overflow_flag, 1'b0);
    unit_run = 2'b00;
  endtask

  // 8-bit reload from a zero high byte, then split with unit 1 frozen
  task automatic t_modes();
    int n;
    logic [15:0] b0;
    unit_a_mode = QCT_MODE_8RELD;
    unit_b_mode = QCT_MODE_SPLIT;
    unit_clock_select_bits = 2'b01;
    unit_counter_mode = 2'b00;
    unit_irq_en = 2'b10;
    unit_run = 2'b01;
    shared_prescale_field = QCT_SCA_SYS4;
    do_reset();
    wait_hi(0, 300, n);
    check("8-bit reload cycles", n, 256);
    check("8-bit reload high", unit_a_count_q[15:8], 8'h00);
    b0 = unit_b_count_q;
    unit_a_mode = QCT_MODE_SPLIT;
    unit_run = 2'b11;
    wait_hi(3, 1100, n);
    near("split high cycles", n, 1024, 4);
    check("unit b held", unit_b_count_q, b0);
    check("unit b flag", unit_b_overflow_flag, 1'b0);
    check("unit b irq", irq_req[1], 1'b1);
    unit_flag_clr = 2'b10;
    step(1);
    unit_flag_clr = 2'b00;
    step(1);
    check("hi flag cleared", unit_a_hi_overflow_flag, 1'b0);
    unit_run = 2'b00;
    unit_irq_en = 2'b00;
    unit_a_mode = QCT_MODE_16BIT;
    unit_b_mode = QCT_MODE_16BIT;
  endtask

  task automatic t_rt2();
    int n;
    rt_split = 2'b01;
    rt_run = 2'b01;
    rt2_reload = 16'h00f0;
    rt_irq_en = 4'b0001;
    wait_hi(1, 300, n);
    pulse_rt_clr(4'b0001);
    wait_hi(1, 40, n);
    near("t2 sys period", n, 16, 2);
    check("t2 reload", rt2_count_q[7:0], 8'hf0);
    check("t2 irq", irq_req[2], 1'b1);
    rt2_clk_lo = QCT_TCK_SYS12;
    pulse_rt_clr(4'b0001);
    wait_hi(1, 250, n);
    pulse_rt_clr(4'b0001);
    wait_hi(1, 250, n);
    near("t2 sys12 period", n, 190, 4);
  endtask

  task automatic t_susp();
    int n;
    logic [15:0] s2;
    suspend = 1'b1;
    rt_run = 2'b11;
    rt_split = 2'b11;
    rt3_reload = 16'h00fc;
    rt_irq_en = 4'b0100;
    step(2);
    s2 = rt2_count_q;
    wait_hi(2, 13000, n);
    pulse_rt_clr(4'b0100);
    wait_hi(2, 300, n);
    near("t3 ext period", n, 191, 4);
    check("wake", wake_req, 1'b1);
    check("t3 irq", irq_req[3], 1'b1);
    check("t3 reload", rt3_count_q[7:0], 8'hfc);
    check("t2 held", rt2_count_q, s2);
    suspend = 1'b0;
    step(1);
    check("wake off", wake_req, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    do_reset();
    step(1);
    check("a count rst", unit_a_count_q, QCT_CNT_RST);
    check("b count rst", unit_b_count_q, QCT_CNT_RST);
    check("t2 count rst", rt2_count_q, QCT_CNT_RST);
    check("t3 count rst", rt3_count_q, QCT_CNT_RST);
    check("irq rst", {wake_req, irq_req, rt_flags_q}, 9'h000);
    t_pins();
    t_presc();
    t_wrap13();
    t_modes();
    t_rt2();
    t_susp();
    test_done();
  end
endmodule
`default_nettype wire
